// ===== core/adsf_dev.sv
// converter end: functional states and serial frame handling
//
// Contract
// - three states reset, acquire, convert only
// - host holds clear pin low minimum width
// - app clear: defaults, ready low, lanes released
// - default clear is power-on with longer settle
// - host releases clear with select, sclk low
// - after exit delay enter acquire, ready high
// - clear high: select rise and conversion end change state
// - acquire after power-up, clear, each conversion
// - clear fall to reset, select rise converts
// - internal clock times conversion, select ignored
// - host waits ready rise or max conversion; this host waits ready rise only
// - host spaces starts by conversion plus acquire
// - frame from select fall to next rise
// - frame start: ready low, clear, load, no_operation
// - capture edge: count up, shift input in
// - launch edge: next out_word bit onto lanes, shifter msb past 32
// - frame end: release lanes, decode, ready low
// - 32 or more captures give valid command
// - short frame acts as no_operation
// - long frame decodes last 32 bits
`timescale 1ns/10ps
`default_nettype none
module adsf_dev (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   adsf_if.dev              lnk,
   input  wire logic [31:0] out_word,
   input  wire logic        app_clear_select,
   output logic [31:0]      cmd_word,
   output logic             cmd_valid,
   output logic             frame_short,
   output logic             cfg_clear,
   output logic             por_clear,
   output logic             conv_start,
   output logic             acquiring
);
   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic                     cs_meta;
   logic                     cs_s;
   logic                     cs_q;
   logic                     rst_meta;
   logic                     rst_s;
   logic                     rst_q;
   logic                     cs_rise;
   logic                     cs_fall;
   logic                     rst_fall;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_meta  <= 1'b0;
         cs_s     <= 1'b0;
         cs_q     <= 1'b0;
         rst_meta <= 1'b0;
         rst_s    <= 1'b0;
         rst_q    <= 1'b0;
      end else if (ce) begin
         cs_meta  <= lnk.conversion_start_select;
         cs_s     <= cs_meta;
         cs_q     <= cs_s;
         rst_meta <= lnk.hw_clear_n;
         rst_s    <= rst_meta;
         rst_q    <= rst_s;
      end
   end

   assign cs_rise  = cs_s & ~cs_q;
   assign cs_fall  = ~cs_s & cs_q;
   assign rst_fall = ~rst_s & rst_q;

   // ----------------------------------------------------------------------
   // functional states
   // ----------------------------------------------------------------------
   adsf_pkg::adsf_state_t    state;
   logic [15:0]              wait_cnt;
   logic                     por_mode;
   logic                     ready;
   logic                     in_frame;
   logic [15:0]              exit_last;

   // power-on exit waits longer so analog parts settle
   assign exit_last = por_mode ? 16'(adsf_pkg::POR_CYC - 1)
                               : 16'(adsf_pkg::APP_CYC - 1);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state    <= adsf_pkg::ST_RESET;
         wait_cnt <= 16'h0000;
         por_mode <= 1'b1;
         ready    <= 1'b0;
      end else if (ce) begin
         case (state)
            adsf_pkg::ST_RESET: begin
               ready <= 1'b0;
               if (!rst_s || cs_s) begin
                  wait_cnt <= 16'h0000;
               end else if (wait_cnt == exit_last) begin
                  state <= adsf_pkg::ST_ACQ;
                  ready <= 1'b1;
               end else begin
                  wait_cnt <= wait_cnt + 16'h0001;
               end
            end
            adsf_pkg::ST_ACQ: begin
               if (rst_fall) begin
                  state    <= adsf_pkg::ST_RESET;
                  wait_cnt <= 16'h0000;
                  por_mode <= ~app_clear_select;
                  ready    <= 1'b0;
               end else if (cs_rise) begin
                  state    <= adsf_pkg::ST_CONV;
                  wait_cnt <= 16'h0000;
                  ready    <= 1'b0;
               end else if (cs_fall) begin
                  ready <= 1'b0;
               end
            end
            adsf_pkg::ST_CONV: begin
               if (rst_fall) begin
                  state    <= adsf_pkg::ST_RESET;
                  wait_cnt <= 16'h0000;
                  por_mode <= ~app_clear_select;
               end else if (wait_cnt == 16'(adsf_pkg::CONV_CYC - 1)) begin
                  state <= adsf_pkg::ST_ACQ;
                  ready <= 1'b1;
               end else begin
                  wait_cnt <= wait_cnt + 16'h0001;
               end
            end
            default: begin
               state <= adsf_pkg::ST_RESET;
               ready <= 1'b0;
            end
         endcase
      end
   end

   // clear pulses pick app or power-on
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_clear  <= 1'b0;
         por_clear  <= 1'b0;
         conv_start <= 1'b0;
      end else if (ce) begin
         cfg_clear  <= rst_fall && state != adsf_pkg::ST_RESET &&
                       app_clear_select;
         // default is a full power-on clear
         por_clear  <= rst_fall && state != adsf_pkg::ST_RESET &&
                       !app_clear_select;
         conv_start <= state == adsf_pkg::ST_ACQ && !rst_fall && cs_rise;
      end
   end

   assign acquiring = state == adsf_pkg::ST_ACQ;

   // ----------------------------------------------------------------------
   // frame control, clk side
   // ----------------------------------------------------------------------
   logic                     oe;
   logic                     clr_cnt;
   logic [31:0]              word_q;
   logic [31:0]              in_shift;
   logic [adsf_pkg::CNT_W-1:0] cap_cnt;
   logic                     frame_ok;

   // count saturates at 32, so 32 or more reads as full
   assign frame_ok = cap_cnt == 6'(adsf_pkg::FRAME_BITS);

   // frame runs from select fall to rise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_frame <= 1'b0;
         oe       <= 1'b0;
         clr_cnt  <= 1'b1;
         word_q   <= adsf_pkg::NO_OPERATION;
      end else if (ce) begin
         if (state != adsf_pkg::ST_ACQ || rst_fall) begin
            in_frame <= 1'b0;
            oe       <= 1'b0;
            clr_cnt  <= 1'b1;
         end else if (cs_fall) begin
            in_frame <= 1'b1;
            oe       <= 1'b1;
            clr_cnt  <= 1'b0;
            word_q   <= out_word;
         end else if (cs_rise) begin
            in_frame <= 1'b0;
            oe       <= 1'b0;
         end
      end
   end

   // snapshot is safe: sclk is parked low when select rises
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cmd_word    <= adsf_pkg::NO_OPERATION;
         cmd_valid   <= 1'b0;
         frame_short <= 1'b0;
      end else if (ce) begin
         cmd_valid <= 1'b0;
         if (state == adsf_pkg::ST_ACQ && !rst_fall && cs_fall) begin
            cmd_word <= adsf_pkg::NO_OPERATION;
         end else if (state == adsf_pkg::ST_ACQ && !rst_fall && cs_rise &&
                      in_frame) begin
            cmd_valid   <= 1'b1;
            frame_short <= !frame_ok;
            // full frame gives the command word
            cmd_word    <= frame_ok ? in_shift : adsf_pkg::NO_OPERATION;
         end
      end
   end

   // ----------------------------------------------------------------------
   // link side, clocked by sclk
   // ----------------------------------------------------------------------
   logic                     sdo_bit;
   logic                     launched;

   // capture edge counts and shifts in
   always_ff @(posedge lnk.sclk or posedge clr_cnt) begin
      if (clr_cnt) begin
         cap_cnt  <= '0;
         in_shift <= 32'h0000_0000;
      end else begin
         // register keeps the last 32 bits
         in_shift <= {in_shift[30:0], lnk.sdi};
         if (!frame_ok) begin
            cap_cnt <= cap_cnt + 6'h01;
         end
      end
   end

   // launch edge presents the next msb
   always_ff @(negedge lnk.sclk or posedge clr_cnt) begin
      if (clr_cnt) begin
         sdo_bit  <= 1'b0;
         launched <= 1'b0;
      end else begin
         launched <= 1'b1;
         // past 32 bits the input shifter msb passes input through
         sdo_bit  <= cap_cnt[5] ? in_shift[31] : word_q[~cap_cnt[4:0]];
      end
   end

   // lanes released outside frames and in reset
   assign lnk.serial_output_lanes = launched ? sdo_bit : word_q[31];
   assign lnk.sdo_oe              = oe;
   assign lnk.ready_strobe        = ready;
endmodule
`default_nettype wire

// ===== core/adsf_pkg.sv
// constants and types shared by both ends of the converter serial link
package adsf_pkg;
   // ----------------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------------
   localparam int          FRAME_BITS = 32;
   localparam int          CNT_W      = 6;
   localparam logic [31:0] NO_OPERATION = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // timing, figures in ns
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   localparam int T_CONV_NS       = 500;
   localparam int T_CONV_MAX_NS   = 700;
   localparam int T_ACQ_MIN_NS    = 300;
   localparam int T_WL_RST_NS     = 100;
   localparam int T_D_RST_POR_NS  = 20000;
   localparam int T_D_RST_APP_NS  = 1000;

   // conversion and settling delays are least times: round up
   localparam int CONV_CYC    = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACQ_MIN_CYC = (T_ACQ_MIN_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
   localparam int WL_RST_CYC  = (T_WL_RST_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
   localparam int POR_CYC     = (T_D_RST_POR_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
   localparam int APP_CYC     = (T_D_RST_APP_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
   // longest conversion, rounded down; the host does not use it as a timeout
   localparam int CONV_MAX_CYC = T_CONV_MAX_NS / CLK_PERIOD_NS;

   // host link pacing, in clk cycles
   // covers three link-clock periods of select sync plus output load
   localparam int SETUP_CYC  = 20;
   localparam int SCLK_HALF  = 4;

   // ----------------------------------------------------------------------
   // state encodings
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {ST_RESET, ST_ACQ, ST_CONV} adsf_state_t;
   typedef enum logic [2:0] {
      H_RST, H_RWAIT, H_IDLE, H_SETUP, H_SHIFT, H_END, H_CONV, H_ACQ
   } adsf_hstate_t;
endpackage

// ===== core/adsf_if.sv
// pins between host controller and converter
`timescale 1ns/10ps
`default_nettype none
interface adsf_if;
   logic conversion_start_select;
   logic hw_clear_n;
   logic sclk;
   logic sdi;
   logic serial_output_lanes;
   logic sdo_oe;
   logic ready_strobe;
   logic sdo_line;

   // released lane reads low; no pull modelled
   assign sdo_line = sdo_oe & serial_output_lanes;

   modport host (
      output conversion_start_select,
      output hw_clear_n,
      output sclk,
      output sdi,
      input  sdo_line,
      input  ready_strobe
   );
   modport dev (
      input  conversion_start_select,
      input  hw_clear_n,
      input  sclk,
      input  sdi,
      output serial_output_lanes,
      output sdo_oe,
      output ready_strobe
   );
endinterface
`default_nettype wire

// ===== core/adsf_host.sv
// host controller end: clear pin, frames, conversion pacing
`timescale 1ns/10ps
`default_nettype none
module adsf_host #(
   parameter int FRAME_LEN = 32
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   adsf_if.host             lnk,
   input  wire logic        start,
   input  wire logic [31:0] tx_word,
   input  wire logic        clear_req,
   output logic             busy,
   output logic             done,
   output logic [31:0]      rx_word
);
   // command bits go last in long frames
   localparam int LEAD = (FRAME_LEN > 32) ? FRAME_LEN - 32 : 0;

   // ----------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------
   logic        rdy_meta;
   logic        rdy_s;
   logic        rdy_q;
   logic        sdo_meta;
   logic        sdo_s;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdy_meta <= 1'b0;
         rdy_s    <= 1'b0;
         rdy_q    <= 1'b0;
         sdo_meta <= 1'b0;
         sdo_s    <= 1'b0;
      end else if (ce) begin
         rdy_meta <= lnk.ready_strobe;
         rdy_s    <= rdy_meta;
         rdy_q    <= rdy_s;
         sdo_meta <= lnk.sdo_line;
         sdo_s    <= sdo_meta;
      end
   end

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   adsf_pkg::adsf_hstate_t hstate;
   logic [15:0] cnt;
   logic [7:0]  bit_cnt;
   logic [31:0] tx_sh;
   logic [31:0] rx_sh;
   logic        rdy_rise;
   logic        cs_o;
   logic        clr_o;
   logic        sclk_o;
   logic        sdi_o;

   // only a fresh rise counts: ready already high says nothing
   assign rdy_rise = rdy_s & ~rdy_q;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hstate  <= adsf_pkg::H_RST;
         cnt     <= 16'h0000;
         bit_cnt <= 8'h00;
         tx_sh   <= 32'h0000_0000;
         rx_sh   <= 32'h0000_0000;
         cs_o    <= 1'b0;
         clr_o   <= 1'b0;
         sclk_o  <= 1'b0;
         sdi_o   <= 1'b0;
         busy    <= 1'b1;
         done    <= 1'b0;
         rx_word <= 32'h0000_0000;
      end else if (ce) begin
         done <= 1'b0;
         case (hstate)
            adsf_pkg::H_RST: begin
               if (cnt == 16'h0004) begin
                  cs_o <= 1'b0;
               end
               if (cnt == 16'(adsf_pkg::WL_RST_CYC - 1)) begin
                  clr_o  <= 1'b1;
                  cnt    <= 16'h0000;
                  hstate <= adsf_pkg::H_RWAIT;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            adsf_pkg::H_RWAIT: begin
               // clear stays high, select starts work
               if (rdy_rise) begin
                  cs_o   <= 1'b1;
                  hstate <= adsf_pkg::H_CONV;
               end
            end
            adsf_pkg::H_IDLE: begin
               if (clear_req) begin
                  clr_o  <= 1'b0;
                  cnt    <= 16'h0000;
                  busy   <= 1'b1;
                  hstate <= adsf_pkg::H_RST;
               end else if (start) begin
                  cs_o    <= 1'b0;
                  cnt     <= 16'h0000;
                  bit_cnt <= 8'h00;
                  busy    <= 1'b1;
                  hstate  <= adsf_pkg::H_SETUP;
                  // long frames pad ahead of command
                  if (LEAD == 0) begin
                     sdi_o <= tx_word[31];
                     tx_sh <= {tx_word[30:0], 1'b0};
                  end else begin
                     sdi_o <= 1'b0;
                     tx_sh <= tx_word;
                  end
               end
            end
            adsf_pkg::H_SETUP: begin
               // converter syncs select and loads its word first
               if (cnt == 16'(adsf_pkg::SETUP_CYC - 1)) begin
                  cnt    <= 16'h0000;
                  hstate <= adsf_pkg::H_SHIFT;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            adsf_pkg::H_SHIFT: begin
               if (cnt == 16'(adsf_pkg::SCLK_HALF - 1)) begin
                  // sample just before the capture edge
                  if (bit_cnt < 8'h20) begin
                     rx_sh <= {rx_sh[30:0], sdo_s};
                  end
                  sclk_o <= 1'b1;
                  cnt    <= cnt + 16'h0001;
               end else if (cnt == 16'(2 * adsf_pkg::SCLK_HALF - 1)) begin
                  sclk_o <= 1'b0;
                  cnt    <= 16'h0000;
                  if (bit_cnt == 8'(FRAME_LEN - 1)) begin
                     hstate <= adsf_pkg::H_END;
                  end else begin
                     bit_cnt <= bit_cnt + 8'h01;
                     if (int'(bit_cnt) + 1 >= LEAD) begin
                        sdi_o <= tx_sh[31];
                        tx_sh <= {tx_sh[30:0], 1'b0};
                     end
                  end
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            adsf_pkg::H_END: begin
               // sclk parked low before select rises
               if (cnt == 16'(adsf_pkg::SETUP_CYC - 1)) begin
                  cs_o    <= 1'b1;
                  cnt     <= 16'h0000;
                  done    <= 1'b1;
                  rx_word <= rx_sh;
                  hstate  <= adsf_pkg::H_CONV;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            adsf_pkg::H_CONV: begin
               // wait for ready to rise again
               if (rdy_rise) begin
                  cnt    <= 16'h0000;
                  hstate <= adsf_pkg::H_ACQ;
               end
            end
            adsf_pkg::H_ACQ: begin
               if (cnt == 16'(adsf_pkg::ACQ_MIN_CYC - 1)) begin
                  busy   <= 1'b0;
                  hstate <= adsf_pkg::H_IDLE;
               end else begin
                  cnt <= cnt + 16'h0001;
               end
            end
            default: begin
               hstate <= adsf_pkg::H_IDLE;
            end
         endcase
      end
   end

   assign lnk.conversion_start_select = cs_o;
   assign lnk.hw_clear_n              = clr_o;
   assign lnk.sclk                    = sclk_o;
   assign lnk.sdi                     = sdi_o;
endmodule
`default_nettype wire

// ===== test/adsf_chk.sv
// pin-level assertions on the host to converter link
`timescale 1ns/10ps
`default_nettype none
module adsf_chk (
   input wire logic lclk,
   input wire logic nrst,
   input wire logic conversion_start_select,
   input wire logic hw_clear_n,
   input wire logic sclk,
   input wire logic sdo_oe,
   input wire logic ready_strobe
);
   logic cs;
   assign cs = conversion_start_select;

   default clocking @(posedge lclk); endclocking
   default disable iff (!nrst);

   // ----------------------------------------------------------------
   // frame edges
   // ----------------------------------------------------------------
   sequence s_start;
      $fell(cs) && hw_clear_n;
   endsequence
   sequence s_end;
      $rose(cs) && hw_clear_n;
   endsequence

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_clear_ready_low: assert property (
      (!hw_clear_n)[*4] |-> !ready_strobe) else $error("ready in clear");
   a_clear_lanes_off: assert property (
      (!hw_clear_n)[*2] |-> !sdo_oe) else $error("lanes in clear");
   a_exit_pins_low: assert property (
      $rose(hw_clear_n) |-> !cs && !sclk) else $error("exit pins");
   a_start_sclk_low: assert property (
      s_start |-> !sclk) else $error("sclk at start");
   a_host_waits_ready: assert property (
      s_start |-> $past(ready_strobe)) else $error("early frame");
   a_start_ready_low: assert property (
      s_start |-> ##[1:4] !ready_strobe) else $error("ready at start");
   a_start_lanes_on: assert property (
      s_start ##1 (!cs)[*4] |-> sdo_oe) else $error("lanes not driven");
   a_end_lanes_off: assert property (
      s_end |-> ##[1:4] !sdo_oe) else $error("lanes at end");
   a_end_ready_low: assert property (
      s_end ##1 cs[*5] |-> !ready_strobe) else $error("ready in conv");
endmodule
`default_nettype wire

// ===== test/adsf_state_and_serial_frame_bench.sv
// self-checking bench joining host and converter ends
`timescale 1ns/10ps
`default_nettype none
module adc_state_and_serial_frame_bench;
   logic        clk = 1'b0;
   logic        lclk = 1'b0;
   logic        nrst = 1'b0;
   logic        start, clear_req, app_sel, busy, done;
   logic        cv, fs, cfgc, porc, cv2, fs2, cst2, pcst2;
   logic        got, got2, sfs2, scfg, spor;
   logic [31:0] tx, ow, ow2, rx, cw, cw2, gcw, gcw2;
   logic [63:0] w, r;
   logic [31:0] cnr [3] = '{32'h0, 32'hffffffff, 32'h8000_0001};
   int          nconv2 = 0;
   integer      num_errors = 0;
   integer      cmp_count = 0;
   integer      seed = 32'h279a16f8;

   adsf_if l1 ();
   adsf_if l2 ();
   adsf_host adsf_host_inst (.clk(clk), .nrst(nrst), .ce(1'b1),
      .lnk(l1.host), .start(start), .tx_word(tx), .clear_req(clear_req),
      .busy(busy), .done(done), .rx_word(rx));
   adsf_dev adsf_dev_inst (.clk(lclk), .nrst(nrst), .ce(1'b1),
      .lnk(l1.dev), .out_word(ow), .app_clear_select(app_sel),
      .cmd_word(cw), .cmd_valid(cv), .frame_short(fs), .cfg_clear(cfgc),
      .por_clear(porc), .conv_start(), .acquiring());
   // second converter faces the bench, which breaks host rules on purpose
   adsf_dev adsf_dev_inst2 (.clk(lclk), .nrst(nrst), .ce(1'b1),
      .lnk(l2.dev), .out_word(ow2), .app_clear_select(1'b0),
      .cmd_word(cw2), .cmd_valid(cv2), .frame_short(fs2), .cfg_clear(),
      .por_clear(), .conv_start(cst2), .acquiring());
   adsf_chk adsf_chk_inst (.lclk(lclk), .nrst(nrst),
      .conversion_start_select(l1.conversion_start_select),
      .hw_clear_n(l1.hw_clear_n), .sclk(l1.sclk), .sdo_oe(l1.sdo_oe),
      .ready_strobe(l1.ready_strobe));

   initial forever #5 clk = ~clk;
   initial begin
      #7;
      forever #15 lclk = ~lclk;
   end

   // sticky capture of pulses from the link clock domain
   always @(posedge lclk) begin
      if (cv === 1'b1) begin
         got <= 1'b1;
         gcw <= cw;
      end
      if (cv2 === 1'b1) begin
         got2 <= 1'b1;
         gcw2 <= cw2;
      end
      if (fs2 === 1'b1) sfs2 <= 1'b1;
      if (cfgc === 1'b1) scfg <= 1'b1;
      if (porc === 1'b1) spor <= 1'b1;
      if (cst2 === 1'b1 && pcst2 !== 1'b1) nconv2 <= nconv2 + 1;
      pcst2 <= cst2;
   end

   task automatic chk(input logic ok, input string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wait_idle();
      repeat (3) @(negedge clk);
      for (int i = 0; i < 30000 && (busy !== 1'b0 ||
           l1.ready_strobe !== 1'b1); i++) @(negedge clk);
   endtask

   task automatic rdy2();
      for (int i = 0; i < 30000 && l2.ready_strobe !== 1'b1; i++)
         @(negedge clk);
   endtask

   task automatic frame(input logic [31:0] t, input logic [31:0] o);
      tx = t;
      ow = o;
      got = 1'b0;
      @(negedge clk) start = 1'b1;
      @(negedge clk) start = 1'b0;
      for (int i = 0; i < 5000 && done !== 1'b1; i++) @(negedge clk);
      chk(rx === o, "read word");
      repeat (10) @(negedge lclk);
      chk(got === 1'b1 && gcw === t, "command word");
      chk(fs === 1'b0, "full frame not short");
      wait_idle();
   endtask

   task automatic run_clear(input logic app);
      app_sel = app;
      scfg = 1'b0;
      spor = 1'b0;
      @(negedge clk) clear_req = 1'b1;
      @(negedge clk) clear_req = 1'b0;
      wait_idle();
      chk(scfg === app, "config clear");
      chk(spor === ~app, "power-on clear");
      chk(l1.ready_strobe === 1'b1, "ready after clear");
   endtask

   // bit-level host on the second link, sclk idle low
   task automatic raw(input int n);
      rdy2();
      // first start after a clear carries no frame
      if (l2.conversion_start_select !== 1'b1) begin
         l2.conversion_start_select = 1'b1;
         repeat (20) @(negedge clk);
         rdy2();
      end
      got2 = 1'b0;
      nconv2 = 0;
      r = '0;
      repeat (adsf_pkg::ACQ_MIN_CYC) @(negedge clk);
      l2.conversion_start_select = 1'b0;
      repeat (8) @(negedge clk);
      sfs2 = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         l2.sdi = w[i];
         repeat (9) @(negedge clk);
         r[i] = l2.sdo_line;
         l2.sclk = 1'b1;
         repeat (9) @(negedge clk);
         l2.sclk = 1'b0;
      end
      repeat (8) @(negedge clk);
      l2.conversion_start_select = 1'b1;
      repeat (12) @(negedge clk);
      l2.conversion_start_select = 1'b0;
      repeat (6) @(negedge clk);
      l2.conversion_start_select = 1'b1;
      rdy2();
   endtask

   initial begin
      #600us;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end

   initial begin
      start = 1'b0;
      clear_req = 1'b0;
      app_sel = 1'b0;
      tx = 32'h0;
      ow = 32'h0;
      ow2 = 32'h0;
      w = 64'h0;
      l2.conversion_start_select = 1'b0;
      l2.hw_clear_n = 1'b0;
      l2.sclk = 1'b0;
      l2.sdi = 1'b0;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (adsf_pkg::WL_RST_CYC) @(negedge clk);
      l2.hw_clear_n = 1'b1;
      wait_idle();
      chk(l1.ready_strobe === 1'b1, "ready after power-up");
      foreach (cnr[k]) frame(cnr[k], ~cnr[k]);
      for (int k = 0; k < 6; k++) frame($random(seed), $random(seed));
      $display("test frames done");
      run_clear(1'b1);
      frame($random(seed), $random(seed));
      run_clear(1'b0);
      frame($random(seed), $random(seed));
      $display("test clears done");
      w = {$random(seed), $random(seed)};
      ow2 = $random(seed);
      raw(40);
      chk(r[39:8] === ow2, "long read");
      chk(got2 === 1'b1 && gcw2 === w[31:0], "long command");
      chk(fs2 === 1'b0, "long not short");
      chk(nconv2 === 1, "one conversion");
      raw(20);
      chk(r[19:0] === ow2[31:12], "short read");
      chk(sfs2 === 1'b1, "short flagged");
      chk(got2 === 1'b1 && gcw2 === adsf_pkg::NO_OPERATION,
          "short write dropped");
      $display("test edge frames done");
      final_report();
   end
endmodule
`default_nettype wire
